// ---- logic/accel_irq_output_lowg_cfg.sv ----
`timescale 1ns/100ps
// interrupt output stage and low-g configuration
module accel_irq_output_lowg_cfg #(
  parameter int AXIS_W    = 10,
  parameter int SRC_N     = 8,
  parameter int TICK_CYC  = irq_cfg_pkg::HOLD_TICK_CYC,
  parameter int STEP_CYC  = irq_cfg_pkg::LOWG_STEP_CYC
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       resetn,
  // register port
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  input  wire logic [irq_cfg_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [irq_cfg_pkg::DATA_W-1:0] reg_wdata,
  output logic [irq_cfg_pkg::DATA_W-1:0]  reg_rdata,
  // acceleration magnitudes and range
  input  wire logic [AXIS_W-1:0]          mag_x,
  input  wire logic [AXIS_W-1:0]          mag_y,
  input  wire logic [AXIS_W-1:0]          mag_z,
  input  wire logic [1:0]                 g_range,
  // other sources and pin mapping, bit 0 is low-g
  input  wire logic [SRC_N-1:1]           irq_src,
  input  wire logic [SRC_N-1:0]           map_pin_a,
  input  wire logic [SRC_N-1:0]           map_pin_b,
  // interrupt pins
  output logic                            first_irq_pin_out,
  output logic                            first_irq_pin_oe,
  output logic                            second_irq_pin_out,
  output logic                            second_irq_pin_oe,
  // derived settings
  output logic [8:0]                      highg_hysteresis_level,
  output logic                            lowg_flag
);
  import irq_cfg_pkg::*;

  localparam int TICK_W = $clog2(TICK_CYC + 1);
  localparam int STEP_W = $clog2(STEP_CYC + 1);

  typedef struct packed {
    logic                pin_a_polarity;
    logic                pin_a_drive_select;
    logic                pin_b_polarity;
    logic                pin_b_drive_select;
    logic [3:0]          hold_mode;
    logic                clear;
    logic [7:0]          lowg_delay;
    logic [7:0]          lowg_threshold;
    logic [1:0]          highg_hysteresis;
    logic                lowg_mode;
    logic [1:0]          lowg_hysteresis;
    logic [TICK_W-1:0]   tick_div;
    logic                tick;
    logic [STEP_W-1:0]   step_div;
    logic                step;
    logic [DATA_W-1:0]   rdata;
    logic                pin_a_out;
    logic                pin_a_oe;
    logic                pin_b_out;
    logic                pin_b_oe;
    logic [8:0]          hy_level;
    logic                lowg;
  } top_regs_type;

  top_regs_type        cur;
  top_regs_type        next_cur;
  logic                lowg_event;
  logic [SRC_N-1:0]    sources;
  logic                raw_a;
  logic                raw_b;
  logic                held_a;
  logic                held_b;

  // pin level and enable, returned as {out, oe}
  function automatic logic [1:0] pin_drive(input logic act, input logic pol,
                                           input logic drv);
    logic lvl;
    lvl = pol ? act : ~act;
    if (drv) begin
      pin_drive = {1'b0, ~lvl};
    end else begin
      pin_drive = {lvl, 1'b1};
    end
  endfunction

  // read-back of one register, reserved and write-only bits as zero
  function automatic logic [DATA_W-1:0] read_reg(input top_regs_type r,
                                                 input logic [ADDR_W-1:0] a);
    read_reg = '0;
    case (a)
      REG_PIN_CFG: begin
        read_reg[PIN_A_POL_BIT] = r.pin_a_polarity;
        read_reg[PIN_A_DRV_BIT] = r.pin_a_drive_select;
        read_reg[PIN_B_POL_BIT] = r.pin_b_polarity;
        read_reg[PIN_B_DRV_BIT] = r.pin_b_drive_select;
      end
      REG_HOLD: begin
        read_reg[HOLD_MODE_LSB +: 4] = r.hold_mode;
      end
      REG_LOWG_DELAY: begin
        read_reg = r.lowg_delay;
      end
      REG_LOWG_THR: begin
        read_reg = r.lowg_threshold;
      end
      REG_HYST: begin
        read_reg[HIGHG_HY_LSB +: 2] = r.highg_hysteresis;
        read_reg[LOWG_MODE_BIT]     = r.lowg_mode;
        read_reg[LOWG_HY_LSB +: 2]  = r.lowg_hysteresis;
      end
      default: begin
        read_reg = '0;
      end
    endcase
  endfunction

  // source vector and pin mapping
  always_comb begin
    sources = {irq_src, lowg_event};
    raw_a   = |(sources & map_pin_a);
    raw_b   = |(sources & map_pin_b);
  end

  // register writes, tick dividers and pin drive
  always_comb begin
    next_cur       = cur;
    next_cur.clear = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        REG_PIN_CFG: begin
          next_cur.pin_a_polarity     = reg_wdata[PIN_A_POL_BIT];
          next_cur.pin_a_drive_select = reg_wdata[PIN_A_DRV_BIT];
          next_cur.pin_b_polarity     = reg_wdata[PIN_B_POL_BIT];
          next_cur.pin_b_drive_select = reg_wdata[PIN_B_DRV_BIT];
        end
        REG_HOLD: begin
          next_cur.hold_mode = reg_wdata[HOLD_MODE_LSB +: 4];
          next_cur.clear     = reg_wdata[CLEAR_BIT];
        end
        REG_LOWG_DELAY: begin
          next_cur.lowg_delay = reg_wdata;
        end
        REG_LOWG_THR: begin
          next_cur.lowg_threshold = reg_wdata;
        end
        REG_HYST: begin
          next_cur.highg_hysteresis = reg_wdata[HIGHG_HY_LSB +: 2];
          next_cur.lowg_mode        = reg_wdata[LOWG_MODE_BIT];
          next_cur.lowg_hysteresis  = reg_wdata[LOWG_HY_LSB +: 2];
        end
        default: begin
          next_cur.clear = 1'b0;
        end
      endcase
    end
    // read data registered one cycle after the strobe
    if (reg_rd) begin
      next_cur.rdata = read_reg(cur, reg_addr);
    end
    // 250 us tick for the hold timers
    next_cur.tick = 1'b0;
    if (cur.tick_div == TICK_W'(TICK_CYC - 1)) begin
      next_cur.tick_div = '0;
      next_cur.tick     = 1'b1;
    end else begin
      next_cur.tick_div = cur.tick_div + TICK_W'(1);
    end
    // 2 ms step for the low-g delay
    next_cur.step = 1'b0;
    if (cur.step_div == STEP_W'(STEP_CYC - 1)) begin
      next_cur.step_div = '0;
      next_cur.step     = 1'b1;
    end else begin
      next_cur.step_div = cur.step_div + STEP_W'(1);
    end
    // pin drive from held state
    {next_cur.pin_a_out, next_cur.pin_a_oe} =
      pin_drive(held_a, cur.pin_a_polarity, cur.pin_a_drive_select);
    {next_cur.pin_b_out, next_cur.pin_b_oe} =
      pin_drive(held_b, cur.pin_b_polarity, cur.pin_b_drive_select);
    // high-g hysteresis scaled by range
    next_cur.hy_level = 9'(cur.highg_hysteresis) << (HIGHG_HY_SHIFT + 3'(g_range));
    next_cur.lowg     = lowg_event;
  end

  // state register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cur                    <= '0;
      cur.pin_a_polarity     <= PIN_CFG_RST[PIN_A_POL_BIT];
      cur.pin_a_drive_select <= PIN_CFG_RST[PIN_A_DRV_BIT];
      cur.pin_b_polarity     <= PIN_CFG_RST[PIN_B_POL_BIT];
      cur.pin_b_drive_select <= PIN_CFG_RST[PIN_B_DRV_BIT];
      cur.hold_mode          <= HOLD_MODE_RST;
      cur.lowg_delay         <= LOWG_DELAY_RST;
      cur.lowg_threshold     <= LOWG_THR_RST;
      cur.highg_hysteresis   <= HIGHG_HY_RST;
      cur.lowg_mode          <= LOWG_MODE_RST;
      cur.lowg_hysteresis    <= LOWG_HY_RST;
      cur.pin_a_oe           <= 1'b1;
      cur.pin_b_oe           <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  // low-g detector
  lowg_detect #(
    .AXIS_W          (AXIS_W)
  ) u_lowg (
    .clk             (clk),
    .resetn          (resetn),
    .mag_x           (mag_x),
    .mag_y           (mag_y),
    .mag_z           (mag_z),
    .sum_mode        (cur.lowg_mode),
    .lowg_threshold  (cur.lowg_threshold),
    .lowg_hysteresis (cur.lowg_hysteresis),
    .delay           (cur.lowg_delay),
    .step_tick       (cur.step),
    .lowg_event      (lowg_event)
  );

  // hold stage for the first pin
  irq_hold_stage u_hold_a (
    .clk    (clk),
    .resetn (resetn),
    .mode   (cur.hold_mode),
    .clear  (cur.clear),
    .tick   (cur.tick),
    .raw    (raw_a),
    .held   (held_a)
  );

  // hold stage for the second pin
  irq_hold_stage u_hold_b (
    .clk    (clk),
    .resetn (resetn),
    .mode   (cur.hold_mode),
    .clear  (cur.clear),
    .tick   (cur.tick),
    .raw    (raw_b),
    .held   (held_b)
  );

  // outputs straight from flops
  assign reg_rdata              = cur.rdata;
  assign first_irq_pin_out      = cur.pin_a_out;
  assign first_irq_pin_oe       = cur.pin_a_oe;
  assign second_irq_pin_out     = cur.pin_b_out;
  assign second_irq_pin_oe      = cur.pin_b_oe;
  assign highg_hysteresis_level = cur.hy_level;
  assign lowg_flag              = cur.lowg;

endmodule

// ---- logic/irq_cfg_pkg.sv ----
package irq_cfg_pkg;

  // register port
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam logic [7:0]  REG_RSVD        = 8'h1F;
  localparam logic [7:0]  REG_PIN_CFG     = 8'h20;
  localparam logic [7:0]  REG_HOLD        = 8'h21;
  localparam logic [7:0]  REG_LOWG_DELAY  = 8'h22;
  localparam logic [7:0]  REG_LOWG_THR    = 8'h23;
  localparam logic [7:0]  REG_HYST        = 8'h24;

  // reset values
  localparam logic [3:0]  PIN_CFG_RST     = 4'h5;
  localparam logic [3:0]  HOLD_MODE_RST   = 4'h0;
  localparam logic [7:0]  LOWG_DELAY_RST  = 8'h09;
  localparam logic [7:0]  LOWG_THR_RST    = 8'h30;
  localparam logic [1:0]  HIGHG_HY_RST    = 2'h2;
  localparam logic        LOWG_MODE_RST   = 1'b0;
  localparam logic [1:0]  LOWG_HY_RST     = 2'h1;

  // field positions
  localparam int          PIN_A_POL_BIT   = 0;
  localparam int          PIN_A_DRV_BIT   = 1;
  localparam int          PIN_B_POL_BIT   = 2;
  localparam int          PIN_B_DRV_BIT   = 3;
  localparam int          CLEAR_BIT       = 7;
  localparam int          HOLD_MODE_LSB   = 0;
  localparam int          HIGHG_HY_LSB    = 6;
  localparam int          LOWG_MODE_BIT   = 2;
  localparam int          LOWG_HY_LSB     = 0;

  // timing
  localparam int          CLK_HZ          = 40_000_000;
  localparam int          HOLD_TICK_US    = 250;
  localparam int          HOLD_TICK_CYC   = CLK_HZ / 1_000_000 * HOLD_TICK_US;
  localparam int          LOWG_STEP_MS    = 2;
  localparam int          LOWG_STEP_CYC   = CLK_HZ / 1000 * LOWG_STEP_MS;
  localparam int          HOLD_CNT_W      = 16;

  // hold durations in 250 us ticks
  localparam logic [15:0] TICKS_250US     = 16'h0001;
  localparam logic [15:0] TICKS_500US     = 16'h0002;
  localparam logic [15:0] TICKS_1MS       = 16'h0004;
  localparam logic [15:0] TICKS_12MS5     = 16'h0032;
  localparam logic [15:0] TICKS_25MS      = 16'h0064;
  localparam logic [15:0] TICKS_50MS      = 16'h00C8;
  localparam logic [15:0] TICKS_500MS     = 16'h07D0;
  localparam logic [15:0] TICKS_2S        = 16'h1F40;
  localparam logic [15:0] TICKS_4S        = 16'h3E80;
  localparam logic [15:0] TICKS_8S        = 16'h7D00;

  // hysteresis steps in threshold units of 7.81 mg
  localparam logic [4:0]  LOWG_HY_STEP    = 5'h10;
  localparam logic [2:0]  HIGHG_HY_SHIFT  = 3'h4;

  // hold-mode codes
  typedef enum logic [3:0] {
    HOLD_NONE_A  = 4'b0000,
    HOLD_T500MS  = 4'b0010,
    HOLD_T2S     = 4'b0100,
    HOLD_T4S     = 4'b0101,
    HOLD_T8S     = 4'b0110,
    HOLD_LATCH   = 4'b0111,
    HOLD_NONE_B  = 4'b1000,
    HOLD_T250US  = 4'b1001,
    HOLD_T500US  = 4'b1010,
    HOLD_T1MS    = 4'b1011,
    HOLD_T12MS5  = 4'b1100,
    HOLD_T25MS   = 4'b1101,
    HOLD_T50MS   = 4'b1110
  } hold_mode_type;

  // hold length in ticks, zero when the code is not a timed one
  function automatic logic [15:0] hold_ticks(input logic [3:0] mode);
    case (mode)
      HOLD_T500MS: hold_ticks = TICKS_500MS;
      HOLD_T2S:    hold_ticks = TICKS_2S;
      HOLD_T4S:    hold_ticks = TICKS_4S;
      HOLD_T8S:    hold_ticks = TICKS_8S;
      HOLD_T250US: hold_ticks = TICKS_250US;
      HOLD_T500US: hold_ticks = TICKS_500US;
      HOLD_T1MS:   hold_ticks = TICKS_1MS;
      HOLD_T12MS5: hold_ticks = TICKS_12MS5;
      HOLD_T25MS:  hold_ticks = TICKS_25MS;
      HOLD_T50MS:  hold_ticks = TICKS_50MS;
      default:     hold_ticks = 16'h0000;
    endcase
  endfunction

  // true for the two pass-through codes
  function automatic logic is_passthru(input logic [3:0] mode);
    is_passthru = (mode == HOLD_NONE_A) || (mode == HOLD_NONE_B);
  endfunction

endpackage

// ---- logic/irq_hold_stage.sv ----
`timescale 1ns/100ps
// holds one pin's interrupt according to the hold mode
module irq_hold_stage (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // configuration
  input  wire logic [3:0] mode,
  input  wire logic       clear,
  input  wire logic       tick,
  // interrupt in and out
  input  wire logic       raw,
  output logic            held
);
  import irq_cfg_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LATCH = 2'b01,
    ST_TIMED = 2'b10
  } hold_state_type;

  typedef struct packed {
    hold_state_type         state;
    logic [HOLD_CNT_W-1:0]  count;
    logic                   held;
  } hold_regs_type;

  hold_regs_type cur;
  hold_regs_type next_cur;

  // hold sequencing, a new assertion wins over a clear
  always_comb begin
    next_cur = cur;
    if (is_passthru(mode)) begin
      next_cur.state = ST_IDLE;
      next_cur.count = '0;
      next_cur.held  = raw;
    end else begin
      case (cur.state)
        ST_IDLE: begin
          if (raw) begin
            next_cur.held = 1'b1;
            if (hold_ticks(mode) == '0) begin
              next_cur.state = ST_LATCH;
            end else begin
              next_cur.state = ST_TIMED;
              next_cur.count = hold_ticks(mode);
            end
          end else begin
            next_cur.held = 1'b0;
          end
        end
        ST_LATCH: begin
          if (clear && !raw) begin
            next_cur.state = ST_IDLE;
            next_cur.held  = 1'b0;
          end
        end
        ST_TIMED: begin
          if (clear && !raw) begin
            next_cur.state = ST_IDLE;
            next_cur.held  = 1'b0;
            next_cur.count = '0;
          end else if (raw && hold_ticks(mode) != '0) begin
            next_cur.count = hold_ticks(mode);       // retrigger restarts the hold
          end else if (tick) begin
            if (cur.count <= 16'h0001) begin
              next_cur.state = ST_IDLE;
              next_cur.held  = 1'b0;
              next_cur.count = '0;
            end else begin
              next_cur.count = cur.count - 16'h0001;
            end
          end
        end
        default: begin
          next_cur.state = ST_IDLE;
          next_cur.held  = 1'b0;
          next_cur.count = '0;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cur <= '{state: ST_IDLE, count: '0, held: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign held = cur.held;

endmodule

// ---- logic/lowg_detect.sv ----
`timescale 1ns/100ps
// low-g condition check with persistence delay and hysteresis
module lowg_detect #(
  parameter int AXIS_W = 10
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // acceleration magnitudes in 7.81 mg units
  input  wire logic [AXIS_W-1:0] mag_x,
  input  wire logic [AXIS_W-1:0] mag_y,
  input  wire logic [AXIS_W-1:0] mag_z,
  // configuration
  input  wire logic              sum_mode,
  input  wire logic [7:0]        lowg_threshold,
  input  wire logic [1:0]        lowg_hysteresis,
  input  wire logic [7:0]        delay,
  input  wire logic              step_tick,
  // result
  output logic                   lowg_event
);
  import irq_cfg_pkg::*;

  localparam int SUM_W = AXIS_W + 2;

  typedef struct packed {
    logic [8:0] count;
    logic       active;
  } lowg_regs_type;

  lowg_regs_type      cur;
  lowg_regs_type      next_cur;
  logic [SUM_W-1:0]   limit;
  logic [SUM_W-1:0]   total;
  logic               below;

  // threshold with hysteresis added once asserted
  always_comb begin
    limit = SUM_W'(lowg_threshold);
    if (cur.active) begin
      limit = limit + SUM_W'(lowg_hysteresis) * SUM_W'(LOWG_HY_STEP);
    end
    total = SUM_W'(mag_x) + SUM_W'(mag_y) + SUM_W'(mag_z);
    if (sum_mode) begin
      below = total < limit;
    end else begin
      below = (SUM_W'(mag_x) < limit) && (SUM_W'(mag_y) < limit)
              && (SUM_W'(mag_z) < limit);
    end
  end

  // persistence count in 2 ms steps
  always_comb begin
    next_cur = cur;
    if (!below) begin
      next_cur.count  = '0;
      next_cur.active = 1'b0;
    end else if (!cur.active && step_tick) begin
      if (cur.count == {1'b0, delay}) begin
        next_cur.active = 1'b1;
      end else begin
        next_cur.count = cur.count + 9'h001;
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cur <= '{count: '0, active: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign lowg_event = cur.active;

endmodule

// ---- test/irq_cfg_chk.sv ----
`timescale 1ns/100ps
// port-level checks of pin drive, hold, clear and low-g timing
module irq_cfg_chk #(
  parameter int AXIS_W   = 10,
  parameter int SRC_N    = 8,
  parameter int TICK_CYC = 4,
  parameter int STEP_CYC = 8
) (
  // clock, reset, register port
  input wire logic                           clk,
  input wire logic                           resetn,
  input wire logic                           reg_wr,
  input wire logic                           reg_rd,
  input wire logic [irq_cfg_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [irq_cfg_pkg::DATA_W-1:0] reg_wdata,
  input wire logic [irq_cfg_pkg::DATA_W-1:0] reg_rdata,
  // sources and range
  input wire logic [AXIS_W-1:0]              mag_x,
  input wire logic [AXIS_W-1:0]              mag_y,
  input wire logic [AXIS_W-1:0]              mag_z,
  input wire logic [1:0]                     g_range,
  input wire logic [SRC_N-1:1]               irq_src,
  input wire logic [SRC_N-1:0]               map_pin_a,
  // outputs
  input wire logic                           first_irq_pin_out,
  input wire logic                           first_irq_pin_oe,
  input wire logic                           second_irq_pin_out,
  input wire logic                           second_irq_pin_oe,
  input wire logic [8:0]                     highg_hysteresis_level,
  input wire logic                           lowg_flag
);
  import irq_cfg_pkg::*;
  logic [3:0]  pin, mode;
  logic [7:0]  dly, thr, calm;
  logic [1:0]  hyh;
  logic        sum, hit_a, lva, cnd, pol;
  logic [15:0] qa, lowc;
  // pin a level with pull-up, mapped source and low-g condition
  assign lva   = first_irq_pin_oe ? first_irq_pin_out : 1'b1;
  assign pol   = pin[PIN_A_POL_BIT];
  assign hit_a = |(irq_src & map_pin_a[SRC_N-1:1]);
  assign cnd   = sum ? ({2'b00, mag_x} + mag_y + mag_z) < thr
                     : (mag_x < thr) && (mag_y < thr) && (mag_z < thr);
  // settings shadow and calm, quiet and condition counters
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin  <= PIN_CFG_RST;
      mode <= HOLD_MODE_RST;
      dly  <= LOWG_DELAY_RST;
      thr  <= LOWG_THR_RST;
      hyh  <= HIGHG_HY_RST;
      sum  <= LOWG_MODE_RST;
      calm <= 8'h00;
      qa   <= 16'h0000;
      lowc <= 16'h0000;
    end else begin
      calm <= reg_wr ? 8'h00 : calm + 8'(calm != 8'hFF);
      qa   <= (hit_a || map_pin_a[0]) ? 16'h0000 : qa + 16'(qa != 16'hFFFF);
      lowc <= cnd ? lowc + 16'(lowc != 16'hFFFF) : 16'h0000;
      if (reg_wr && reg_addr == REG_PIN_CFG) pin <= reg_wdata[3:0];
      if (reg_wr && reg_addr == REG_HOLD) mode <= reg_wdata[3:0];
      if (reg_wr && reg_addr == REG_LOWG_DELAY) dly <= reg_wdata;
      if (reg_wr && reg_addr == REG_LOWG_THR) thr <= reg_wdata;
      if (reg_wr && reg_addr == REG_HYST) begin
        hyh <= reg_wdata[7:6];
        sum <= reg_wdata[LOWG_MODE_BIT];
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_rd7;
    reg_rd && reg_addr == REG_HOLD |=> !reg_rdata[CLEAR_BIT];
  endproperty
  a_rd7: assert property (p_rd7) else $error("clear bit read back");
  property p_pp;
    calm > 2 && !pin[PIN_A_DRV_BIT] |-> first_irq_pin_oe;
  endproperty
  a_pp: assert property (p_pp) else $error("push-pull pin released");
  property p_od;
    calm > 2 && pin[PIN_B_DRV_BIT] |-> !(second_irq_pin_oe && second_irq_pin_out);
  endproperty
  a_od: assert property (p_od) else $error("open drain pin driven high");
  property p_idle;
    calm > 2 && qa > 3 && mode[2:0] == 3'h0 |-> lva != pol;
  endproperty
  a_idle: assert property (p_idle) else $error("idle pin at asserted level");
  property p_on;
    hit_a [*3] ##0 (calm > 2 && mode[2:0] == 3'h0) |-> lva == pol;
  endproperty
  a_on: assert property (p_on) else $error("mapped source not on pin");
  property p_latch;
    calm > 2 && mode inside {4'h1, 4'h3, 4'h7, 4'hF} && lva == pol |=> lva == $past(pol);
  endproperty
  a_latch: assert property (p_latch) else $error("latched pin dropped");
  property p_clr;
    reg_wr && reg_addr == REG_HOLD && reg_wdata[CLEAR_BIT] && qa > 3
      ##1 (qa > 4 && !reg_wr) ##1 (qa > 5 && !reg_wr) |=> qa == 0 || lva != pol;
  endproperty
  a_clr: assert property (p_clr) else $error("clear left pin asserted");
  property p_tmd;
    calm > 2 && mode == HOLD_T250US && qa == 16'(2 * TICK_CYC + 4) |-> lva != pol;
  endproperty
  a_tmd: assert property (p_tmd) else $error("short hold too long");
  property p_hys;
    calm > 2 && $stable(g_range) |->
      highg_hysteresis_level == (9'({hyh, 4'h0}) << g_range);
  endproperty
  a_hys: assert property (p_hys) else $error("high-g hysteresis wrong");
  property p_lowg;
    $rose(lowg_flag) && calm > lowc |-> lowc >= dly * STEP_CYC;
  endproperty
  a_lowg: assert property (p_lowg) else $error("low-g flag too early");
  c_lowg: cover property ($rose(lowg_flag));
  c_clr: cover property (reg_wr && reg_addr == REG_HOLD && reg_wdata[CLEAR_BIT]);
  c_od: cover property (pin[PIN_A_DRV_BIT] && !first_irq_pin_oe);
endmodule

bind accel_irq_output_lowg_cfg irq_cfg_chk #(.AXIS_W(AXIS_W), .SRC_N(SRC_N),
  .TICK_CYC(TICK_CYC), .STEP_CYC(STEP_CYC)) u_chk (.*);

// ---- test/irq_pin_host.sv ----
`timescale 1ns/100ps
// host end of one irq line, pulled up when released
module irq_pin_host (
  // drive from the device
  input  wire logic pin_out,
  input  wire logic pin_oe,
  // level the host sees
  output logic      level
);
  // released line rises to the pull-up
  assign level = pin_oe ? pin_out : 1'b1;
endmodule

// ---- test/test_accel_irq_output_lowg_cfg.sv ----
`timescale 1ns/100ps
// register, pin, hold and low-g tests
module test_accel_irq_output_lowg_cfg;
  import irq_cfg_pkg::*;
  localparam int T = 4;
  localparam int S = 8;
  logic       clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [9:0] mag_x = 10'h3FF, mag_y = 10'h3FF, mag_z = 10'h3FF;
  logic [1:0] g_range = 2'h0;
  logic [7:1] irq_src = 7'h00;
  logic [7:0] map_pin_a = 8'h02, map_pin_b = 8'h02;
  logic       ao, ae, bo, be, lva, lvb, lowg_flag, pa = 1'b1, pb = 1'b1;
  logic [8:0] hyl;
  int         n_mismatch = 0, n_tests = 0, n;
  int         tk[16] = '{0, -1, 2000, -1, 8000, 16000, 32000, -1,
                         0, 1, 2, 4, 50, 100, 200, -1};
  // 40 MHz clock
  always #12.5 clk = ~clk;
  accel_irq_output_lowg_cfg #(.TICK_CYC(T), .STEP_CYC(S)) dut (
    .clk, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .mag_x, .mag_y, .mag_z, .g_range, .irq_src, .map_pin_a, .map_pin_b,
    .first_irq_pin_out(ao), .first_irq_pin_oe(ae), .second_irq_pin_out(bo),
    .second_irq_pin_oe(be), .highg_hysteresis_level(hyl), .lowg_flag);
  irq_pin_host ha (.pin_out(ao), .pin_oe(ae), .level(lva));
  irq_pin_host hb (.pin_out(bo), .pin_oe(be), .level(lvb));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // expected level from asserted state and polarity
  task automatic pins(input logic ea, input logic eb);
    #1 chk({lvb, lva}, {eb ~^ pb, ea ~^ pa});
  endtask
  // set magnitudes and count cycles until the flag reaches e
  task automatic settle(input logic [9:0] x, y, z, input logic e, output int k);
    @(posedge clk);
    mag_x <= x;
    mag_y <= y;
    mag_z <= z;
    k = 0;
    #1;
    while (lowg_flag !== e && k < 60) begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // main sequence
  initial begin
    cyc(3);
    resetn <= 1'b1;
    rd(REG_RSVD, 8'h00);
    rd(REG_PIN_CFG, 8'h05);
    rd(REG_HOLD, 8'h00);
    rd(REG_LOWG_DELAY, 8'h09);
    rd(REG_LOWG_THR, 8'h30);
    rd(REG_HYST, 8'h81);
    rd(8'h30, 8'h00);
    wr(REG_RSVD, 8'hFF);
    rd(REG_RSVD, 8'h00);
    wr(REG_HYST, 8'hFF);
    rd(REG_HYST, 8'hC7);
    for (int r = 0; r < 4; r++) begin
      g_range <= 2'(r);
      cyc(3);
      #1 chk(hyl, 16'(48 << r));
    end
    wr(REG_HYST, 8'h81);
    for (int c = 0; c < 16; c++) begin
      wr(REG_PIN_CFG, 8'(c));
      pa = c[0];
      pb = c[2];
      cyc(4);
      pins(0, 0);
      irq_src[1] <= 1'b1;
      cyc(4);
      pins(1, 1);
      irq_src[1] <= 1'b0;
    end
    wr(REG_PIN_CFG, 8'h06);
    pa = 1'b0;
    pb = 1'b1;
    map_pin_b <= 8'h04;
    irq_src <= 7'h01;
    cyc(4);
    pins(1, 0);
    irq_src <= 7'h02;
    cyc(4);
    pins(0, 1);
    irq_src <= 7'h00;
    map_pin_b <= 8'h02;
    for (int m = 0; m < 16; m++) begin
      wr(REG_HOLD, 8'h80 | 8'(m));
      cyc(4);
      irq_src[1] <= 1'b1;
      cyc(2);
      irq_src[1] <= 1'b0;
      if (tk[m] == 0) begin
        cyc(4);
        pins(0, 0);
      end else if (tk[m] < 0 || tk[m] > 8000) begin
        cyc(20);
        pins(1, 1);
        wr(REG_HOLD, 8'(m));
        cyc(4);
        pins(1, 1);
        wr(REG_HOLD, 8'h80 | 8'(m));
        cyc(4);
        pins(0, 0);
      end else begin
        cyc(tk[m] * T - T);
        pins(1, 1);
        cyc(T + 6);
        pins(0, 0);
      end
    end
    wr(REG_HOLD, 8'h80);
    wr(REG_LOWG_DELAY, 8'h02);
    map_pin_a <= 8'h01;
    settle(10'h020, 10'h020, 10'h020, 1'b1, n);
    chk(16'(n >= 2 * S && n <= 3 * S + 4), 16'h0001);
    cyc(1);
    pins(1, 0);
    settle(10'h038, 10'h038, 10'h038, 1'b0, n);
    chk(16'(n), 16'd60);
    settle(10'h040, 10'h040, 10'h040, 1'b0, n);
    chk(16'(n < 8), 16'h0001);
    wr(REG_HYST, 8'h85);
    settle(10'h020, 10'h020, 10'h020, 1'b1, n);
    chk(16'(n), 16'd60);
    settle(10'h008, 10'h008, 10'h008, 1'b1, n);
    chk(16'(n >= 2 * S && n <= 3 * S + 4), 16'h0001);
    settle(10'h3FF, 10'h3FF, 10'h3FF, 1'b0, n);
    wr(REG_HYST, 8'h81);
    settle(10'h040, 10'h000, 10'h000, 1'b1, n);
    chk(16'(n), 16'd60);
    close_out;
  end
  // watchdog against a hang
  initial begin
    cyc(90000);
    n_mismatch++;
    close_out;
  end
endmodule
